/* rtl/nrcg_gate.sv */
// Function
// - a usb 2.0 fixed device has its clock stopped after it suspends and the stop wait elapses.
// - a usb 3.0 non-hub fixed device has its clock stopped after it suspends and the wait elapses.
// - a usb 3.0 hub fixed device has its clock stopped only once both port waits are satisfied.
// - resume on usb 2.0 port 1 during the stop wait cancels the stop.
// - a U3 exit on usb 3.0 port 1 during the stop wait cancels the stop.
// - resume on usb 2.0 port 1 restarts the clock within 1 ms for usb 2.0 devices and hubs.
// - usb 2.0 port 1 leaving suspend restarts the clock within 1 ms for usb 2.0 devices.
// - usb 2.0 upstream leaving suspend restarts the clock within 1 ms for usb 2.0 and hubs.
// - a U3 exit on usb 3.0 port 1 restarts the clock within 1 ms for usb 3.0 devices and hubs.
// - usb 3.0 port 1 leaving suspend restarts the clock within 1 ms for usb 3.0 non-hubs.
// - the clock output starts no later than 300 us after the reset interval ends.
// - the fixed device reset ends no later than 30 ms after the clock output starts.
// - the clock only stops with the stop enable setting on; a stopped clock stays stopped if the setting is then cleared.
// - strap pins stay inputs during reset and for 3 us after its release.
module nrcg_gate #(
  parameter int unsigned STOP_WAIT_CYC   = nrcg_pkg::STOP_WAIT_CYC,
  parameter int unsigned RST_RELEASE_CYC = nrcg_pkg::RST_RELEASE_CYC,
  parameter int unsigned CLK_START_CYC   = nrcg_pkg::CLK_START_CYC,
  parameter int unsigned DIV_HALF        = 1
) (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire logic                CE,
  // configuration
  input  wire nrcg_pkg::nrcg_dev_e DEV_KIND,
  input  wire logic                STOP_ENABLE,
  // port activity
  input  wire nrcg_pkg::nrcg_evt_s EVT,
  // fixed device side
  output logic                     FIXED_DEV_CLOCK_OUT,
  output logic                     FIXED_DEV_RESET_OUT_N,
  output logic                     STRAP_INPUT_PHASE
);

  initial begin
    if (STOP_WAIT_CYC < 1 || STOP_WAIT_CYC >= (1 << nrcg_pkg::CNT_W) ||
        RST_RELEASE_CYC < 1 || RST_RELEASE_CYC >= (1 << nrcg_pkg::CNT_W) ||
        CLK_START_CYC < 1 || CLK_START_CYC <= nrcg_pkg::STRAP_HOLD_CYC ||
        CLK_START_CYC >= (1 << nrcg_pkg::CNT_W) ||
        DIV_HALF < 1 || DIV_HALF >= (1 << nrcg_pkg::DIV_W))
      $error("nrcg_gate: parameter out of range");
  end

  typedef logic [nrcg_pkg::CNT_W-1:0] nrcg_cnt_t;
  typedef logic [nrcg_pkg::DIV_W-1:0] nrcg_div_t;

  localparam nrcg_cnt_t STOP_LAST  = nrcg_cnt_t'(STOP_WAIT_CYC - 1);
  localparam nrcg_cnt_t RSTR_LAST  = nrcg_cnt_t'(RST_RELEASE_CYC - 1);
  localparam nrcg_cnt_t START_LAST = nrcg_cnt_t'(CLK_START_CYC - 1);
  localparam nrcg_cnt_t STRAP_LAST = nrcg_cnt_t'(nrcg_pkg::STRAP_HOLD_CYC - 1);
  localparam nrcg_div_t DIV_LAST   = nrcg_div_t'(DIV_HALF - 1);

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  nrcg_pkg::nrcg_state_e state_r, state_nxt;
  nrcg_cnt_t             cnt_r, cnt_nxt;
  nrcg_div_t             div_r, div_nxt;
  logic                  clk_out_r, clk_out_nxt;
  logic                  rst_n_r, rst_n_nxt;
  logic                  strap_r, strap_nxt;
  logic                  p2_susp_d_r, p3_susp_d_r, up_susp_d_r;
  logic                  suspended;
  logic                  cancel;
  logic                  restart;
  logic                  is_u2;
  logic                  is_u3;
  logic                  is_hub;

  // fixed-device kind flags
  assign is_u2  = (DEV_KIND == nrcg_pkg::NRCG_DEV_U2);
  assign is_u3  = (DEV_KIND == nrcg_pkg::NRCG_DEV_U3);
  assign is_hub = (DEV_KIND == nrcg_pkg::NRCG_DEV_U3HUB);

  // suspend condition per device kind
  always_comb begin
    unique case (DEV_KIND)
      nrcg_pkg::NRCG_DEV_U2:    suspended = EVT.p1_u2_suspended;
      nrcg_pkg::NRCG_DEV_U3:    suspended = EVT.p1_u3_suspended;
      nrcg_pkg::NRCG_DEV_U3HUB: suspended = EVT.p1_u2_suspended &&
                                            EVT.p1_u3_suspended;
      default:                  suspended = 1'b0;
    endcase
  end

  // stop-wait cancel conditions
  always_comb begin
    cancel = !suspended;
    if ((is_u2 || is_hub) && EVT.p1_u2_resume)
      cancel = 1'b1;
    if ((is_u3 || is_hub) && EVT.p1_u3_exit)
      cancel = 1'b1;
  end

  // restart triggers for a stopped clock
  always_comb begin
    restart = 1'b0;
    if ((is_u2 || is_hub) && EVT.p1_u2_resume)
      restart = 1'b1;
    if (is_u2 && p2_susp_d_r && !EVT.p1_u2_suspended)
      restart = 1'b1;
    if ((is_u2 || is_hub) && up_susp_d_r && !EVT.up_u2_suspended)
      restart = 1'b1;
    if ((is_u3 || is_hub) && EVT.p1_u3_exit)
      restart = 1'b1;
    if (is_u3 && p3_susp_d_r && !EVT.p1_u3_suspended)
      restart = 1'b1;
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // next state, counter, reset-out and strap phase
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    rst_n_nxt = rst_n_r;
    strap_nxt = strap_r;
    unique case (state_r)
      nrcg_pkg::NRCG_ST_RESET: begin
        cnt_nxt   = '0;
        state_nxt = nrcg_pkg::NRCG_ST_CLK_WAIT;
      end
      nrcg_pkg::NRCG_ST_CLK_WAIT: begin
        if (cnt_r == STRAP_LAST)
          strap_nxt = 1'b0;
        if (cnt_r == START_LAST) begin
          cnt_nxt   = '0;
          state_nxt = nrcg_pkg::NRCG_ST_RST_HOLD;
        end else begin
          cnt_nxt = cnt_r + nrcg_cnt_t'(1);
        end
      end
      nrcg_pkg::NRCG_ST_RST_HOLD: begin
        if (cnt_r == RSTR_LAST) begin
          rst_n_nxt = 1'b1;
          cnt_nxt   = '0;
          state_nxt = nrcg_pkg::NRCG_ST_RUN;
        end else begin
          cnt_nxt = cnt_r + nrcg_cnt_t'(1);
        end
      end
      nrcg_pkg::NRCG_ST_RUN: begin
        cnt_nxt = '0;
        if (STOP_ENABLE && suspended)
          state_nxt = nrcg_pkg::NRCG_ST_STOP_WAIT;
      end
      nrcg_pkg::NRCG_ST_STOP_WAIT: begin
        if (cancel || !STOP_ENABLE) begin
          state_nxt = nrcg_pkg::NRCG_ST_RUN;
        end else if (cnt_r == STOP_LAST) begin
          state_nxt = nrcg_pkg::NRCG_ST_STOPPED;
        end else begin
          cnt_nxt = cnt_r + nrcg_cnt_t'(1);
        end
      end
      nrcg_pkg::NRCG_ST_STOPPED: begin
        cnt_nxt = '0;
        if (restart)
          state_nxt = nrcg_pkg::NRCG_ST_RUN;
      end
      default: state_nxt = nrcg_pkg::NRCG_ST_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // clock divider with clean gating
  // ----------------------------------------------------------------
  // toggles only in running states; stops on a low phase, so no runt pulse
  always_comb begin
    div_nxt     = div_r;
    clk_out_nxt = clk_out_r;
    if (state_r == nrcg_pkg::NRCG_ST_RST_HOLD || state_r == nrcg_pkg::NRCG_ST_RUN ||
        state_r == nrcg_pkg::NRCG_ST_STOP_WAIT ||
        (state_r == nrcg_pkg::NRCG_ST_STOPPED && clk_out_r)) begin
      if (div_r == DIV_LAST) begin
        div_nxt     = '0;
        clk_out_nxt = !clk_out_r;
      end else begin
        div_nxt = div_r + nrcg_div_t'(1);
      end
    end else begin
      div_nxt = '0;
    end
  end

  // state registers, frozen while CE is low
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r     <= nrcg_pkg::NRCG_ST_RESET;
      cnt_r       <= '0;
      div_r       <= '0;
      clk_out_r   <= 1'b0;
      rst_n_r     <= 1'b0;
      strap_r     <= 1'b1;   // strap pins held as inputs
      p2_susp_d_r <= 1'b0;
      p3_susp_d_r <= 1'b0;
      up_susp_d_r <= 1'b0;
    end else if (CE) begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      div_r       <= div_nxt;
      clk_out_r   <= clk_out_nxt;
      rst_n_r     <= rst_n_nxt;
      strap_r     <= strap_nxt;
      p2_susp_d_r <= EVT.p1_u2_suspended;
      p3_susp_d_r <= EVT.p1_u3_suspended;
      up_susp_d_r <= EVT.up_u2_suspended;
    end
  end

  // outputs straight from flops
  assign FIXED_DEV_CLOCK_OUT   = clk_out_r;
  assign FIXED_DEV_RESET_OUT_N = rst_n_r;
  assign STRAP_INPUT_PHASE     = strap_r;

endmodule

/* rtl/nrcg_pkg.sv */
package nrcg_pkg;

  // ----------------------------------------------------------------
  // timing figures and derived cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned STOP_WAIT_MS      = 50;   // hs_suspend_stop_wait, longest
  localparam int unsigned RESTART_US        = 1000; // restart triggers, longest
  localparam int unsigned CLK_START_US      = 300;  // clock start after reset out, longest
  localparam int unsigned RST_RELEASE_MS    = 30;   // reset release after clock start
  localparam int unsigned STRAP_HOLD_US     = 3;    // strap pins stay inputs, least
  localparam int unsigned STOP_WAIT_CYC     = STOP_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned CLK_START_CYC     = CLK_START_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RST_RELEASE_CYC   = RST_RELEASE_MS * (CLK_HZ / 1000);
  localparam int unsigned STRAP_HOLD_CYC    = (STRAP_HOLD_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned RESTART_CYC       = RESTART_US * (CLK_HZ / 1_000_000);

  localparam int unsigned CNT_W             = 24;
  localparam int unsigned DIV_W             = 8;

  // ----------------------------------------------------------------
  // fixed device kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    NRCG_DEV_U2,
    NRCG_DEV_U3,
    NRCG_DEV_U3HUB
  } nrcg_dev_e;

  // port activity events, one-cycle pulses or levels
  typedef struct packed {
    logic p1_u2_suspended;  // usb 2.0 port 1 in suspend (level)
    logic p1_u3_suspended;  // usb 3.0 port 1 in U3 (level)
    logic p1_u2_resume;     // resume sent or seen on usb 2.0 port 1 (pulse)
    logic p1_u3_exit;       // U3 exit sent or seen on usb 3.0 port 1 (pulse)
    logic up_u2_suspended;  // usb 2.0 upstream in suspend (level)
  } nrcg_evt_s;

  typedef enum logic [2:0] {
    NRCG_ST_RESET,
    NRCG_ST_CLK_WAIT,
    NRCG_ST_RST_HOLD,
    NRCG_ST_RUN,
    NRCG_ST_STOP_WAIT,
    NRCG_ST_STOPPED
  } nrcg_state_e;

endpackage

/* tb/nrcg_gate_checker.sv */
module nrcg_chk #(
  parameter int unsigned STOP_WAIT_CYC   = 20,
  parameter int unsigned RST_RELEASE_CYC = 10,
  parameter int unsigned CLK_START_CYC   = 130
) (
  // watched ports
  input wire logic                CLK,
  input wire logic                RST,
  input wire logic                CE,
  input wire nrcg_pkg::nrcg_dev_e DEV_KIND,
  input wire logic                STOP_ENABLE,
  input wire nrcg_pkg::nrcg_evt_s EVT,
  input wire logic                FIXED_DEV_CLOCK_OUT,
  input wire logic                FIXED_DEV_RESET_OUT_N,
  input wire logic                STRAP_INPUT_PHASE
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SW_MAX = STOP_WAIT_CYC + 8;
  localparam int ST_MAX = nrcg_pkg::STRAP_HOLD_CYC - 1;
  localparam int RR_MAX = RST_RELEASE_CYC + 2;
  localparam int CS_MAX = CLK_START_CYC + 4;
  logic [15:0] rel_r, sus_r, idl_r;
  logic        seen_r, ck_q, u2_q, u3_q, up_q, sus, rpl, trig;
  // suspend condition, cancel pulse and restart trigger per kind
  always_comb begin
    sus  = 1'b0;
    rpl  = 1'b0;
    trig = 1'b0;
    case (DEV_KIND)
      nrcg_pkg::NRCG_DEV_U2: begin
        sus  = EVT.p1_u2_suspended;
        rpl  = EVT.p1_u2_resume;
        trig = rpl | (u2_q & ~sus) | (up_q & ~EVT.up_u2_suspended);
      end
      nrcg_pkg::NRCG_DEV_U3: begin
        sus  = EVT.p1_u3_suspended;
        rpl  = EVT.p1_u3_exit;
        trig = rpl | (u3_q & ~sus);
      end
      nrcg_pkg::NRCG_DEV_U3HUB: begin
        sus  = EVT.p1_u2_suspended & EVT.p1_u3_suspended;
        rpl  = EVT.p1_u2_resume | EVT.p1_u3_exit;
        trig = rpl | (up_q & ~EVT.up_u2_suspended);
      end
      default: sus = 1'b0;
    endcase
  end
  // cycle counters since release, in suspend, and with the clock idle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      {rel_r, sus_r, idl_r} <= '0;
      {seen_r, ck_q, u2_q, u3_q, up_q} <= '0;
    end else begin
      rel_r  <= rel_r + 16'h1;
      sus_r  <= (sus & STOP_ENABLE & FIXED_DEV_RESET_OUT_N & ~rpl) ? sus_r + 16'h1 : 16'h0;
      idl_r  <= (FIXED_DEV_CLOCK_OUT != ck_q) ? 16'h0 : idl_r + 16'h1;
      seen_r <= seen_r | FIXED_DEV_CLOCK_OUT;
      {ck_q, u2_q, u3_q, up_q} <= {FIXED_DEV_CLOCK_OUT, EVT.p1_u2_suspended,
                                   EVT.p1_u3_suspended, EVT.up_u2_suspended};
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_restart;
    ##[1:4] $changed(FIXED_DEV_CLOCK_OUT);
  endsequence
  chk_strap_hold: assert property (int'(rel_r) < ST_MAX |-> STRAP_INPUT_PHASE)
    else $error("strap phase ended early");
  chk_clk_start: assert property (rel_r == CS_MAX |-> seen_r)
    else $error("clock output started late");
  chk_rst_after: assert property (FIXED_DEV_RESET_OUT_N |-> seen_r)
    else $error("reset released before clock");
  chk_rst_release: assert property ($rose(seen_r) |-> ##[1:RR_MAX] FIXED_DEV_RESET_OUT_N)
    else $error("reset released late");
  chk_stop_early: assert property (sus_r > 3 && sus_r < STOP_WAIT_CYC |-> idl_r < 2)
    else $error("clock stopped before wait");
  chk_stop_late: assert property (sus_r == SW_MAX |-> idl_r >= 2)
    else $error("clock not stopped after wait");
  chk_stop_enable: assert property (idl_r >= 3 && FIXED_DEV_RESET_OUT_N |-> STOP_ENABLE)
    else $error("clock stopped while disabled");
  chk_restart_fast: assert property (trig && idl_r >= 2 |-> s_restart)
    else $error("clock not restarted");
  // a trigger one cycle back legally restarts the clock, so it is left out here
  chk_stay_stopped: assert property (idl_r >= 2 && FIXED_DEV_RESET_OUT_N && !trig &&
    !$past(trig) && !$changed(FIXED_DEV_CLOCK_OUT)
    |=> $stable(FIXED_DEV_CLOCK_OUT) && !FIXED_DEV_CLOCK_OUT)
    else $error("stopped clock moved");
endmodule

/* tb/nrcg_fixed_dev.sv */
module nrcg_fixed_dev (
  // clock and reset from the gate
  input  wire logic        clk_in,
  input  wire logic        rst_in_n,
  // observed activity
  output logic      [15:0] edges
);
  timeunit 1ns;
  timeprecision 1ps;
  // counts aux clock edges while out of reset
  always_ff @(posedge clk_in or negedge rst_in_n) begin
    if (!rst_in_n) edges <= 16'h0;
    else edges <= edges + 16'h1;
  end
endmodule

/* tb/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RST = 1'b1, STOP_ENABLE = 1'b1, clk_o, rst_o_n, strap;
  nrcg_pkg::nrcg_dev_e DEV_KIND = nrcg_pkg::NRCG_DEV_U2;
  nrcg_pkg::nrcg_evt_s EVT = '0;
  logic [15:0] edges, e0;
  int errors = 0, tests_run = 0, cyc = 0;
  int trs [8] = '{0, 1, 2, 3, 4, 0, 2, 3};
  always #12.5 CLK = ~CLK;
  nrcg_gate #(.STOP_WAIT_CYC(20), .RST_RELEASE_CYC(10), .CLK_START_CYC(130)) nrcg_gate_i (
    .CLK(CLK), .RST(RST), .CE(1'b1), .DEV_KIND(DEV_KIND), .STOP_ENABLE(STOP_ENABLE),
    .EVT(EVT), .FIXED_DEV_CLOCK_OUT(clk_o), .FIXED_DEV_RESET_OUT_N(rst_o_n),
    .STRAP_INPUT_PHASE(strap));
  nrcg_fixed_dev nrcg_fixed_dev_i (.clk_in(clk_o), .rst_in_n(rst_o_n), .edges(edges));
  task automatic chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run_chk(input logic exp);
    e0 = edges;
    repeat (6) @(negedge CLK);
    chk(edges !== e0, exp);
  endtask
  task automatic fire(input int i);
    case (i)
      0: EVT.p1_u2_resume = 1'b1;
      1: EVT.p1_u2_suspended = 1'b0;
      2: EVT.up_u2_suspended = 1'b0;
      3: EVT.p1_u3_exit = 1'b1;
      default: EVT.p1_u3_suspended = 1'b0;
    endcase
    @(negedge CLK);
    EVT.p1_u2_resume = 1'b0;
    EVT.p1_u3_exit = 1'b0;
  endtask
  task automatic t_por();
    repeat (10) @(negedge CLK);
    RST = 1'b0;
    repeat (100) @(negedge CLK);
    chk(strap, 1'b1);
    repeat (30) @(negedge CLK);
    chk(strap, 1'b0);
    for (int i = 0; i < 300 && rst_o_n !== 1'b1; i++) @(negedge CLK);
    chk(rst_o_n, 1'b1);
    run_chk(1'b1);
    $display("test por done");
  endtask
  task automatic t_stop(input nrcg_pkg::nrcg_dev_e k, input int tr);
    DEV_KIND = k;
    EVT.up_u2_suspended = 1'b1;
    EVT.p1_u2_suspended = (k != nrcg_pkg::NRCG_DEV_U3);
    EVT.p1_u3_suspended = (k != nrcg_pkg::NRCG_DEV_U2);
    repeat (14) @(negedge CLK);
    run_chk(1'b1);
    repeat (10) @(negedge CLK);
    run_chk(1'b0);
    if (k != nrcg_pkg::NRCG_DEV_U3HUB) begin
      fire(k == nrcg_pkg::NRCG_DEV_U2 ? 3 : 0);
      run_chk(1'b0);
    end
    fire(tr);
    run_chk(1'b1);
    EVT = '0;
    repeat (4) @(negedge CLK);
    $display("test stop kind %0d trigger %0d done", k, tr);
  endtask
  task automatic t_hold(input nrcg_pkg::nrcg_dev_e k, input int p, input logic en);
    DEV_KIND = k;
    STOP_ENABLE = en;
    EVT.p1_u2_suspended = 1'b1;
    EVT.p1_u3_suspended = (k != nrcg_pkg::NRCG_DEV_U3HUB);
    repeat (12) @(negedge CLK);
    if (p >= 0) fire(p);
    repeat (12) @(negedge CLK);
    run_chk(1'b1);
    EVT = '0;
    STOP_ENABLE = 1'b1;
    repeat (4) @(negedge CLK);
    $display("test hold kind %0d done", k);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // timeout guard
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    t_por();
    foreach (trs[i]) t_stop(nrcg_pkg::nrcg_dev_e'(2'(i < 3 ? 0 : i < 5 ? 1 : 2)), trs[i]);
    t_hold(nrcg_pkg::NRCG_DEV_U2, 0, 1'b1);
    t_hold(nrcg_pkg::NRCG_DEV_U3, 3, 1'b1);
    t_hold(nrcg_pkg::NRCG_DEV_U3HUB, -1, 1'b1);
    t_hold(nrcg_pkg::NRCG_DEV_U2, -1, 1'b0);
    print_verdict();
  end
endmodule
bind nrcg_gate nrcg_chk #(.STOP_WAIT_CYC(STOP_WAIT_CYC), .RST_RELEASE_CYC(RST_RELEASE_CYC),
  .CLK_START_CYC(CLK_START_CYC)) nrcg_chk_i (.CLK(CLK), .RST(RST), .CE(CE),
  .DEV_KIND(DEV_KIND), .STOP_ENABLE(STOP_ENABLE), .EVT(EVT),
  .FIXED_DEV_CLOCK_OUT(FIXED_DEV_CLOCK_OUT), .FIXED_DEV_RESET_OUT_N(FIXED_DEV_RESET_OUT_N),
  .STRAP_INPUT_PHASE(STRAP_INPUT_PHASE));
